// [rtl/fldiag_pkg.sv]
/*
  Constants, register map and shared decode for the fault supervision
  and diagnostic serial slave of an eight-channel half-bridge driver.
  Assumes a 10 MHz system clock; filter and dead times are in ns.
*/
package fldiag_pkg;

  // ==========================================================
  // Sizes and timing
  // ==========================================================
  localparam int NUM_HB        = 8;
  localparam int NUM_SW        = 16;
  localparam int CNT_W         = 12;
  localparam int SYNC_W        = 38;
  localparam int CLK_PERIOD_NS = 100;

  localparam int DEAD_TIME_NS     = 1000;
  localparam int OC_FILTER_NS     = 10000;
  localparam int OL_FILTER_NS     = 300000;
  localparam int OL_LOW_FILTER_NS = 100000;
  localparam int SETUP_NS         = 100000;

  // Least times, so all round up
  localparam logic [CNT_W-1:0] DEAD_CYC =
    CNT_W'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OC_CYC =
    CNT_W'((OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OL_CYC =
    CNT_W'((OL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OL_LOW_CYC =
    CNT_W'((OL_LOW_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Frame layout
  // ==========================================================
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int         ADDR_LSB   = 2;
  localparam int         OP_BIT     = 7;
  localparam int         DATA_LSB   = 8;

  // ==========================================================
  // Register addresses (one byte each)
  // ==========================================================
  localparam logic [4:0] ADDR_GLOBAL = 5'h00;
  localparam logic [4:0] ADDR_ACT_LO = 5'h01;
  localparam logic [4:0] ADDR_ACT_HI = 5'h02;
  localparam logic [4:0] ADDR_OLCTL  = 5'h03;
  localparam logic [4:0] ADDR_OC_HS  = 5'h04;
  localparam logic [4:0] ADDR_OC_LS  = 5'h05;
  localparam logic [4:0] ADDR_OL_HS  = 5'h06;
  localparam logic [4:0] ADDR_OL_LS  = 5'h07;

  // Global status one bit positions
  localparam int BIT_WARN     = 1;
  localparam int BIT_SHUTDN   = 2;
  localparam int BIT_POR_N    = 3;
  localparam int BIT_SUP_OV   = 4;
  localparam int BIT_SUP_UV   = 5;
  localparam int BIT_LOAD_ERR = 6;

  // Synchroniser reset: chip select idles high
  localparam logic [SYNC_W-1:0] SYNC_RST = 38'h20_0000_0000;

  // Byte of the shadow bank at an address; unmapped reads zero
  function automatic logic [7:0] fldiag_pick(input logic [63:0] bank,
                                             input logic [4:0]  addr);
    logic [7:0] r;
    r = 8'h00;
    if (addr <= ADDR_OL_LS)
      r = bank[{addr[2:0], 3'h0} +: 8];
    return r;
  endfunction

endpackage

// [rtl/fldiag_spi_link.sv]
/*
  Serial-clock side of the diagnostic port: mode 1 shifter, 16 bits.
  Assumes bank_i is frozen by the system side while chip select is
  low, and that the received word is read only after chip select
  has risen, when no serial clock edge can change it.
*/
`timescale 1ns/1ps
module fldiag_spi_link
  import fldiag_pkg::*;
(
  input  logic        sclk_i,
  input  logic        chip_select_n_i,
  input  logic        reset_i,
  input  logic        sdi_i,
  input  logic [63:0] bank_i,
  output logic [15:0] rx_word_o,
  output logic        rx_ok_o,
  output logic        rx_tog_o,
  output logic        sdo_o,
  output logic        sdo_oe_n_o
);
  logic        tx_rst;
  logic        start_ff;
  logic        tog_ff;
  logic        sdo_ff;
  logic        oe_n_ff;
  logic [4:0]  rx_cnt_ff;
  logic [4:0]  tx_cnt_ff;
  logic [15:0] rx_ff;
  logic [7:0]  resp;

  // Chip select high ends the frame without any clock edge
  assign tx_rst = reset_i | chip_select_n_i;

  // ==========================================================
  // Receive on falling edges
  // ==========================================================
  always_ff @(negedge sclk_i or posedge tx_rst) begin
    if (tx_rst) start_ff <= 1'b1;
    else        start_ff <= 1'b0;
  end

  always_ff @(negedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_ff     <= 16'h0000;
      rx_cnt_ff <= 5'h00;
      tog_ff    <= 1'b0;
    end else if (start_ff) begin
      rx_ff     <= {15'h0000, sdi_i};
      rx_cnt_ff <= 5'h01;
      tog_ff    <= ~tog_ff;
    end else begin
      if (rx_cnt_ff < FRAME_BITS)
        rx_ff[rx_cnt_ff[3:0]] <= sdi_i;
      if (rx_cnt_ff != 5'h1F)
        rx_cnt_ff <= rx_cnt_ff + 5'h01;
    end
  end

  // Exactly sixteen clocks and a set lead bit make a word
  assign rx_ok_o   = (rx_cnt_ff == FRAME_BITS) & rx_ff[0];
  assign rx_word_o = rx_ff;
  assign rx_tog_o  = tog_ff;

  // ==========================================================
  // Transmit on rising edges
  // ==========================================================
  // Address bits are in by falling edge 7, before rising edge 9
  assign resp = fldiag_pick(bank_i, rx_ff[ADDR_LSB +: 5]);

  always_ff @(posedge sclk_i or posedge tx_rst) begin
    if (tx_rst) begin
      sdo_ff    <= 1'b0;
      oe_n_ff   <= 1'b1;
      tx_cnt_ff <= 5'h00;
    end else begin
      oe_n_ff <= 1'b0;
      if (tx_cnt_ff < 5'h08)
        sdo_ff <= bank_i[tx_cnt_ff[2:0]];
      else if (tx_cnt_ff < FRAME_BITS)
        sdo_ff <= resp[tx_cnt_ff[2:0]];
      else
        sdo_ff <= 1'b0;
      if (tx_cnt_ff != 5'h1F)
        tx_cnt_ff <= tx_cnt_ff + 5'h01;
    end
  end

  assign sdo_o      = sdo_ff;
  assign sdo_oe_n_o = oe_n_ff;

endmodule // fldiag_spi_link

// [rtl/fldiag_fault_core.sv]
/*
  Fault latching, output gating and register handling for an eight
  half-bridge driver, with the serial diagnostic port instantiated.
  Assumes analog comparators and pins are asynchronous, PWM
  free-wheel indications come from logic on clk_sys_i, and reset_i
  is the logic-supply undervoltage reset.
*/
//
// Contract
// - Overcurrent keeps enable bits, sets per-switch flag and load error
// - Never both switches of a bridge on; dead time between them
// - Warning level latches warning flag until cleared; outputs stay on
// - Shutdown level latches all outputs off until shutdown flag cleared
// - Enables stay 1; flags read 0 only once cleared and condition gone
// - Supply undervoltage: outputs off, registers kept, flag, auto resume
// - Supply overvoltage: outputs off, flag latched, auto resume
// - Logic undervoltage reset: port ignored, outputs off, state reset
// - After reset the power-on indicator reads 0
// - Persistent open load on active switch sets flags; output stays on
// - Host picks lower open-load threshold and filter for two outputs
// - No open-load detection for free-wheeling stages during PWM
// - Each frame carries 16 bits; clock low at select fall
// - Sample input on falling edge, shift output on rising edge
// - Addressed register content returned within the same frame
// - Received word acted on only after chip select rises
// - Serial output released when chip select goes high
// - Writes, clears and reads are whole bytes
// - Device never clears flags itself; host clears them
// - Frames ignored until setup interval after enable rises
// - Expired overcurrent filter latches switch off while flag is set
// - Load error flag sits at bit 6 of global status one
// - Operation bit 1 reads and clears status; 0 only reads
`timescale 1ns/1ps
module fldiag_fault_core
  import fldiag_pkg::*;
(
  input  logic                clk_sys_i,
  input  logic                reset_i,
  input  logic                enable_i,
  input  logic [NUM_HB-1:0]   oc_hs_i,
  input  logic [NUM_HB-1:0]   oc_ls_i,
  input  logic [NUM_HB-1:0]   ol_hs_i,
  input  logic [NUM_HB-1:0]   ol_ls_i,
  input  logic                temp_warn_i,
  input  logic                temp_sd_i,
  input  logic                supply_uv_i,
  input  logic                supply_ov_i,
  input  logic [NUM_SW-1:0]   pwm_freewheel_i,
  input  logic                sclk_i,
  input  logic                chip_select_n_i,
  input  logic                sdi_i,
  output logic [NUM_HB-1:0]   hs_drive_o,
  output logic [NUM_HB-1:0]   ls_drive_o,
  output logic [1:0]          ol_low_threshold_o,
  output logic                sdo_o,
  output logic                sdo_oe_n_o
);

  function automatic logic hit(input logic       wr,
                               input logic [4:0] addr,
                               input logic [4:0] target);
    return wr && (addr == target);
  endfunction

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1_ff;
  logic [SYNC_W-1:0] s2_ff;
  logic [SYNC_W-1:0] s3_ff;
  logic [SYNC_W-1:0] filt_ff;
  logic [NUM_SW-1:0] oc_f;
  logic [NUM_SW-1:0] ol_f;
  logic              warn_f;
  logic              sd_f;
  logic              uv_f;
  logic              ov_f;
  logic              en_f;
  logic              cs_f;

  assign raw = {chip_select_n_i, enable_i, supply_ov_i, supply_uv_i,
                temp_sd_i, temp_warn_i, ol_ls_i, ol_hs_i,
                oc_ls_i, oc_hs_i};

  // A change counts only once the last two stages agree
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s1_ff   <= SYNC_RST;
      s2_ff   <= SYNC_RST;
      s3_ff   <= SYNC_RST;
      filt_ff <= SYNC_RST;
    end else begin
      s1_ff   <= raw;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
    end
  end

  assign oc_f   = filt_ff[15:0];
  assign ol_f   = filt_ff[31:16];
  assign warn_f = filt_ff[32];
  assign sd_f   = filt_ff[33];
  assign uv_f   = filt_ff[34];
  assign ov_f   = filt_ff[35];
  assign en_f   = filt_ff[36];
  assign cs_f   = filt_ff[37];

  // ==========================================================
  // Enable setup interval
  // ==========================================================
  logic [CNT_W-1:0] setup_cnt_ff;
  logic             setup_done_ff;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      setup_cnt_ff  <= 12'h000;
      setup_done_ff <= 1'b0;
    end else if (!en_f) begin
      setup_cnt_ff  <= 12'h000;
      setup_done_ff <= 1'b0;
    end else if (setup_cnt_ff == SETUP_CYC) begin
      setup_done_ff <= 1'b1;
    end else begin
      setup_cnt_ff  <= setup_cnt_ff + 12'h001;
    end
  end

  // ==========================================================
  // Frame acceptance
  // ==========================================================
  logic        cs_q_ff;
  logic        tog_seen_ff;
  logic [15:0] rx_word;
  logic        rx_ok;
  logic        rx_tog;
  logic        frame_end;
  logic        take;
  logic        wr;
  logic [4:0]  addr;
  logic [7:0]  data;

  // Word is only looked at after select is back high
  assign frame_end = cs_f & ~cs_q_ff;
  assign take = frame_end & rx_ok & (rx_tog != tog_seen_ff)
              & setup_done_ff;
  assign addr = rx_word[ADDR_LSB +: 5];
  assign data = rx_word[DATA_LSB +: 8];
  assign wr   = take & rx_word[OP_BIT];

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cs_q_ff     <= 1'b1;
      tog_seen_ff <= 1'b0;
    end else begin
      cs_q_ff <= cs_f;
      if (frame_end)
        tog_seen_ff <= rx_tog;
    end
  end

  // ==========================================================
  // Control registers, written a byte at a time
  // ==========================================================
  logic [NUM_SW-1:0] act_ff;
  logic [1:0]        olctl_ff;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      act_ff   <= 16'h0000;
      olctl_ff <= 2'h0;
    end else begin
      if (hit(wr, addr, ADDR_ACT_LO))
        act_ff[7:0] <= data;
      if (hit(wr, addr, ADDR_ACT_HI))
        act_ff[15:8] <= data;
      if (hit(wr, addr, ADDR_OLCTL))
        olctl_ff <= data[1:0];
    end
  end

  assign ol_low_threshold_o = olctl_ff;

  // ==========================================================
  // Latched flags; a set in the clear cycle wins
  // ==========================================================
  logic              glob_clr;
  logic [NUM_SW-1:0] oc_clr;
  logic [NUM_SW-1:0] ol_clr;
  logic [NUM_SW-1:0] oc_set;
  logic [NUM_SW-1:0] ol_set;
  logic [NUM_SW-1:0] oc_flag_ff;
  logic [NUM_SW-1:0] ol_flag_ff;
  logic              warn_flag_ff;
  logic              sd_flag_ff;
  logic              uv_flag_ff;
  logic              ov_flag_ff;
  logic              por_n_ff;

  assign glob_clr = hit(wr, addr, ADDR_GLOBAL);
  assign oc_clr = {{NUM_HB{hit(wr, addr, ADDR_OC_LS)}},
                   {NUM_HB{hit(wr, addr, ADDR_OC_HS)}}};
  assign ol_clr = {{NUM_HB{hit(wr, addr, ADDR_OL_LS)}},
                   {NUM_HB{hit(wr, addr, ADDR_OL_HS)}}};

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      oc_flag_ff <= 16'h0000;
      ol_flag_ff <= 16'h0000;
    end else begin
      oc_flag_ff <= (oc_flag_ff & ~oc_clr) | oc_set;
      ol_flag_ff <= (ol_flag_ff & ~ol_clr) | ol_set;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      warn_flag_ff <= 1'b0;
      sd_flag_ff   <= 1'b0;
      uv_flag_ff   <= 1'b0;
      ov_flag_ff   <= 1'b0;
      por_n_ff     <= 1'b0;
    end else begin
      warn_flag_ff <= warn_f | (warn_flag_ff & ~glob_clr);
      sd_flag_ff   <= sd_f | (sd_flag_ff & ~glob_clr);
      uv_flag_ff   <= uv_f | (uv_flag_ff & ~glob_clr);
      ov_flag_ff   <= ov_f | (ov_flag_ff & ~glob_clr);
      if (glob_clr)
        por_n_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Per-switch overcurrent and open-load filters
  // ==========================================================
  logic [NUM_SW-1:0] drv;

  assign drv = {ls_drive_o, hs_drive_o};

  for (genvar i = 0; i < NUM_SW; i++) begin : g_sw
    logic [CNT_W-1:0] oc_cnt_ff;
    logic [CNT_W-1:0] ol_cnt_ff;
    logic [CNT_W-1:0] ol_lim;

    // Only the first two high-side outputs have the LED setting
    if (i < 2) begin : g_low
      assign ol_lim = olctl_ff[i % 2] ? OL_LOW_CYC : OL_CYC;
    end else begin : g_std
      assign ol_lim = OL_CYC;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        oc_cnt_ff <= 12'h000;
        ol_cnt_ff <= 12'h000;
      end else begin
        if (drv[i] && oc_f[i]) begin
          if (oc_cnt_ff != OC_CYC)
            oc_cnt_ff <= oc_cnt_ff + 12'h001;
        end else begin
          oc_cnt_ff <= 12'h000;
        end
        // Free-wheeling stage is blanked from open-load detection
        if (drv[i] && ol_f[i] && !pwm_freewheel_i[i]) begin
          if (ol_cnt_ff != ol_lim)
            ol_cnt_ff <= ol_cnt_ff + 12'h001;
        end else begin
          ol_cnt_ff <= 12'h000;
        end
      end
    end

    assign oc_set[i] = (oc_cnt_ff == OC_CYC);
    assign ol_set[i] = (ol_cnt_ff == ol_lim);
  end

  // ==========================================================
  // Output stage gating with dead time
  // ==========================================================
  logic gate_all;

  // Enable bits are never touched; only the drive is removed
  assign gate_all = sd_flag_ff | sd_f | uv_f | ov_f
                  | ~en_f;

  for (genvar b = 0; b < NUM_HB; b++) begin : g_hb
    logic             hs_ok;
    logic             ls_ok;
    logic             hs_q_ff;
    logic             ls_q_ff;
    logic [CNT_W-1:0] dead_ff;

    // Both enables set is treated as a request for neither
    assign hs_ok = act_ff[2*b] & ~act_ff[2*b+1] & ~gate_all
                 & ~oc_flag_ff[b];
    assign ls_ok = act_ff[2*b+1] & ~act_ff[2*b] & ~gate_all
                 & ~oc_flag_ff[b+NUM_HB];

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        hs_q_ff <= 1'b0;
        ls_q_ff <= 1'b0;
        dead_ff <= 12'h000;
      end else begin
        hs_q_ff <= hs_ok & ~ls_q_ff
                 & (hs_q_ff | (dead_ff == 12'h000));
        ls_q_ff <= ls_ok & ~hs_q_ff
                 & (ls_q_ff | (dead_ff == 12'h000));
        if ((hs_q_ff & ~hs_ok) | (ls_q_ff & ~ls_ok))
          dead_ff <= DEAD_CYC;
        else if (dead_ff != 12'h000)
          dead_ff <= dead_ff - 12'h001;
      end
    end

    assign hs_drive_o[b] = hs_q_ff;
    assign ls_drive_o[b] = ls_q_ff;
  end

  // ==========================================================
  // Shadow bank seen by the serial side
  // ==========================================================
  logic [7:0]  gs;
  logic [63:0] bank_ff;

  always_comb begin
    gs           = 8'h00;
    gs[BIT_WARN]     = warn_flag_ff;
    gs[BIT_SHUTDN]   = sd_flag_ff;
    gs[BIT_POR_N]    = por_n_ff;
    gs[BIT_SUP_OV]   = ov_flag_ff;
    gs[BIT_SUP_UV]   = uv_flag_ff;
    gs[BIT_LOAD_ERR] = |{oc_flag_ff, ol_flag_ff};
  end

  // Frozen while select is low so the shifter sees stable words
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i)
      bank_ff <= 64'h0000_0000_0000_0000;
    else if (cs_f)
      bank_ff <= {ol_flag_ff[15:8], ol_flag_ff[7:0],
                  oc_flag_ff[15:8], oc_flag_ff[7:0],
                  {6'h00, olctl_ff}, act_ff[15:8], act_ff[7:0], gs};
  end

  fldiag_spi_link u_link (
    .sclk_i          (sclk_i),
    .chip_select_n_i (chip_select_n_i),
    .reset_i         (reset_i),
    .sdi_i           (sdi_i),
    .bank_i          (bank_ff),
    .rx_word_o       (rx_word),
    .rx_ok_o         (rx_ok),
    .rx_tog_o        (rx_tog),
    .sdo_o           (sdo_o),
    .sdo_oe_n_o      (sdo_oe_n_o)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  AST_NO_SHOOT: assert property (
    (hs_drive_o & ls_drive_o) == 8'h00)
    else $error("both switches of a bridge on");

  AST_DEAD_GAP: assert property (
    $fell(hs_drive_o[0]) |-> (!ls_drive_o[0]) [*8])
    else $error("low side on inside dead time");

  AST_OC_OFF: assert property (
    |oc_flag_ff |=> ((drv & $past(oc_flag_ff)) == 16'h0000))
    else $error("switch on while its overcurrent flag set");

  AST_OC_CAUSE: assert property (
    $rose(oc_flag_ff[0]) |-> $past(drv[0] && oc_f[0]) && gs[BIT_LOAD_ERR])
    else $error("overcurrent flag without cause");

  AST_SHUTDOWN_OFF: assert property (
    sd_flag_ff |=> (drv == 16'h0000))
    else $error("output on during thermal shutdown");

  AST_SUPPLY_OFF: assert property (
    (uv_f || ov_f) |=> (drv == 16'h0000)
      && (!$past(uv_f) || uv_flag_ff) && (!$past(ov_f) || ov_flag_ff))
    else $error("output on during supply fault");

  AST_WARN_LATCH: assert property (
    warn_f |=> warn_flag_ff)
    else $error("warning flag not latched");

  AST_FLAG_KEEP: assert property (
    $fell(warn_flag_ff) || $fell(sd_flag_ff) |-> $past(glob_clr))
    else $error("flag dropped without host clear");

  AST_OL_BLANK: assert property (
    $rose(ol_flag_ff[0]) |-> $past(drv[0] && !pwm_freewheel_i[0]))
    else $error("open load flagged while blanked");

  AST_EARLY_IGNORED: assert property (
    $changed(act_ff) |-> $past(setup_done_ff && frame_end))
    else $error("control written outside accepted frame");

  AST_POR_IND: assert property (
    $rose(por_n_ff) |-> $past(glob_clr))
    else $error("power-on indicator set without clear");

endmodule // fldiag_fault_core

// [sim/fldiag_host_model.sv]
/*
  Host serial master model: mode 1, 16-bit frames, LSB first.
  Assumes the slave samples on falling and shifts on rising edges.
*/
`timescale 1ns/1ps
module fldiag_host_model (
  output logic      sclk_o,
  output logic      chip_select_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sclk_o          = 1'b0;
    chip_select_n_o = 1'b1;
    sdi_o           = 1'b0;
  end

  // ==========================================================
  // Frame transfer; the clock stands still between frames
  // ==========================================================
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    chip_select_n_o = 1'b0;
    sdi_o = 1'b0;
    #600;
    for (int i = 0; i < 16; i++) begin
      sclk_o = 1'b1;
      sdi_o = w[i];
      #62.5;
      sclk_o = 1'b0;
      r[i] = sdo_i;
      #62.5;
    end
    #100;
    chip_select_n_o = 1'b1;
    // Released line must not keep showing the last bit
    sdi_o = ~sdi_o;
    #800;
  endtask
endmodule // fldiag_host_model

// [sim/fldiag_fault_core_tb.sv]
/*
  Self-checking bench for the fault core with a host master model.
  Assumes the package constants and the documented register map.
*/
`timescale 1ns/1ps
module fldiag_fault_core_tb
  import fldiag_pkg::*;
;
  logic clk_sys_i = 1'b0, reset_i = 1'b0, enable_i = 1'b1;
  logic [7:0] oc_hs = 8'h00, oc_ls = 8'h00, ol_hs = 8'h00, ol_ls = 8'h00;
  logic tw = 1'b0, sd = 1'b0, uv = 1'b0, ov = 1'b0;
  logic [15:0] fw = 16'h0000;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n;
  logic sdo_line;
  logic [7:0] hs, ls;
  logic [1:0] olthr;
  logic [15:0] r;
  int bad_count = 0;
  int samples_checked = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  // A released line shows the inverse so a late drive shows up
  assign sdo_line = sdo_oe_n ? ~sdo : sdo;

  fldiag_host_model h (.sclk_o(sclk), .chip_select_n_o(cs_n),
    .sdi_o(sdi), .sdo_i(sdo_line));

  fldiag_fault_core uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .enable_i(enable_i), .oc_hs_i(oc_hs), .oc_ls_i(oc_ls),
    .ol_hs_i(ol_hs), .ol_ls_i(ol_ls), .temp_warn_i(tw),
    .temp_sd_i(sd), .supply_uv_i(uv), .supply_ov_i(ov),
    .pwm_freewheel_i(fw), .sclk_i(sclk), .chip_select_n_i(cs_n),
    .sdi_i(sdi), .hs_drive_o(hs), .ls_drive_o(ls),
    .ol_low_threshold_o(olthr), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #5;
  endtask

  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic frame(input logic [4:0] a, input logic op,
                       input logic [7:0] d);
    h.xfer({d, op, a, 2'b11}, r);
    check({15'h0000, sdo_oe_n}, 16'h0001);
    tick(1);
  endtask

  // Bounded wait on the first high-side drive
  task automatic wait_hs(input logic exp, input int bound);
    for (int i = 0; i < bound && hs[0] !== exp; i++) tick(1);
    if (hs[0] !== exp) begin
      check({15'h0000, hs[0]}, {15'h0000, exp});
      wrap_up();
    end
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_setup();
    frame(ADDR_ACT_LO, 1'b1, 8'h01);
    tick(int'(SETUP_CYC) + 100);
    frame(ADDR_ACT_LO, 1'b0, 8'h00);
    check(r, 16'h0000);
    check({15'h0000, hs[0]}, 16'h0000);
  endtask

  task automatic t_enable();
    frame(ADDR_ACT_LO, 1'b1, 8'h01);
    wait_hs(1'b1, 40);
    check({8'h00, ls}, 16'h0000);
    frame(ADDR_OLCTL, 1'b1, 8'h03);
    tick(3);
    check({14'h0000, olthr}, 16'h0003);
    frame(ADDR_ACT_LO, 1'b0, 8'h00);
    check(r, 16'h0100);
  endtask

  task automatic t_overcurrent();
    oc_hs[0] = 1'b1;
    wait_hs(1'b0, 150);
    frame(ADDR_OC_HS, 1'b0, 8'h00);
    check(r, 16'h0140);
    frame(ADDR_ACT_LO, 1'b0, 8'h00);
    check(r, 16'h0140);
    oc_hs[0] = 1'b0;
    tick(20);
    check({15'h0000, hs[0]}, 16'h0000);
    frame(ADDR_OC_HS, 1'b1, 8'h00);
    wait_hs(1'b1, 40);
  endtask

  task automatic t_temp();
    tw = 1'b1;
    tick(10);
    check({15'h0000, hs[0]}, 16'h0001);
    sd = 1'b1;
    wait_hs(1'b0, 20);
    sd = 1'b0;
    tw = 1'b0;
    tick(20);
    check({15'h0000, hs[0]}, 16'h0000);
    frame(ADDR_GLOBAL, 1'b0, 8'h00);
    check(r, 16'h0606);
    frame(ADDR_GLOBAL, 1'b1, 8'h00);
    wait_hs(1'b1, 40);
    frame(ADDR_GLOBAL, 1'b0, 8'h00);
    check(r, 16'h0808);
  endtask

  task automatic t_supply();
    logic [7:0] e;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) uv = 1'b1;
      else ov = 1'b1;
      wait_hs(1'b0, 20);
      uv = 1'b0;
      ov = 1'b0;
      wait_hs(1'b1, 20);
      e = 8'h08;
      e[k == 0 ? BIT_SUP_UV : BIT_SUP_OV] = 1'b1;
      frame(ADDR_ACT_LO, 1'b0, 8'h00);
      check(r, {8'h01, e});
      frame(ADDR_GLOBAL, 1'b1, 8'h00);
    end
  endtask

  task automatic t_openload();
    fw[0] = 1'b1;
    ol_hs[0] = 1'b1;
    tick(int'(OL_LOW_CYC) + 20);
    frame(ADDR_OL_HS, 1'b0, 8'h00);
    check(r, 16'h0008);
    fw[0] = 1'b0;
    tick(int'(OL_LOW_CYC) + 20);
    check({15'h0000, hs[0]}, 16'h0001);
    ol_hs[0] = 1'b0;
    tick(10);
    frame(ADDR_OL_HS, 1'b1, 8'h00);
    check(r, 16'h0148);
    frame(ADDR_OL_HS, 1'b0, 8'h00);
    check(r, 16'h0008);
  endtask

  task automatic t_reset();
    reset_i = 1'b1;
    tick(2);
    check({7'h00, hs, sdo_oe_n}, 16'h0001);
    reset_i = 1'b0;
    tick(int'(SETUP_CYC) + 20);
    frame(ADDR_ACT_LO, 1'b0, 8'h00);
    check(r, 16'h0000);
  endtask

  initial begin
    #5;
    reset_i = 1'b1;
    tick(4);
    reset_i = 1'b0;
    t_setup();
    t_enable();
    t_overcurrent();
    t_temp();
    t_supply();
    t_openload();
    t_reset();
    wrap_up();
  end
endmodule // fldiag_fault_core_tb
